/* File: hw/sas_params.svh */
// constants of the serial audio port: depths, limits, resets, rates
// assumes inclusion by bare name from the package and the design file
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// --------------------------------------------------------------------
// sizes
// --------------------------------------------------------------------
`define SAS_WORD_W 32
`define SAS_HALF_W 16
`define SAS_FIFO_DEPTH 16
`define SAS_LEN_MIN 5'h01
`define SAS_LEN_16 5'h0F
`define SAS_LEN_8 5'h07

// --------------------------------------------------------------------
// buffer occupancy limits: standard buffer, and enhanced buffer per word size
// --------------------------------------------------------------------
`define SAS_LIM_STD 5'h01
`define SAS_LIM_8 5'h04
`define SAS_LIM_16 5'h02
`define SAS_LIM_32 5'h01

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define SAS_RST_WORD 32'h00000000
`define SAS_RST_CNT 5'h00
`define SAS_RST_DIV 9'h000

// --------------------------------------------------------------------
// shift rates
// --------------------------------------------------------------------
`define SAS_SYS_MHZ 250
`define SAS_DED_MAX_MHZ 50
`define SAS_REMAP_MAX_MHZ 25
`define SAS_DED_HALF ((`SAS_SYS_MHZ + 2 * `SAS_DED_MAX_MHZ - 1) / (2 * `SAS_DED_MAX_MHZ))
`define SAS_REMAP_HALF ((`SAS_SYS_MHZ + 2 * `SAS_REMAP_MAX_MHZ - 1) / (2 * `SAS_REMAP_MAX_MHZ))

`endif

/* File: hw/sas_pkg.sv */
// types of the serial audio port
// assumes sas_params.svh on the include path
`include "sas_params.svh"

package sas_pkg;

  // ------------------------------------------------------------------
  // modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SAS_AUD_I2S,
    SAS_AUD_LEFT,
    SAS_AUD_RIGHT,
    SAS_AUD_PCM
  } sas_audio_t;

  typedef enum logic [1:0] {
    SAS_PINS_4,
    SAS_PINS_3,
    SAS_PINS_2
  } sas_pins_t;

  // ------------------------------------------------------------------
  // configuration and pin bundles
  // ------------------------------------------------------------------
  typedef struct packed {
    logic port_enable;
    logic master;
    logic buffer_enhanced;
    logic framed;
    logic frame_master;
    logic frame_pol;
    logic audio_enable;
    sas_audio_t audio_fmt;
    sas_pins_t pins;
    logic [4:0] word_len_m1;
    logic [7:0] clk_div;
    logic dedicated_pin_select;
  } sas_cfg_t;

  typedef struct packed {
    logic serial_data_out;
    logic serial_data_oe;
    logic shift_clock_out;
    logic shift_clock_oe;
    logic select_out;
    logic select_oe;
  } sas_link_t;

endpackage

/* File: hw/sas_port.sv */
// serial port with framed and audio modes, FIFO buffered both ways
// assumes config is changed only while port_enable is low
`timescale 1ns/1ps
`include "sas_params.svh"

// --------------------------------------------------------------------
// fifo
// --------------------------------------------------------------------
module sas_fifo #(
  parameter int W = `SAS_WORD_W,
  parameter int D = `SAS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW + 1)'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;

  assign in_ready = count != FULL;
  assign out_valid = count != '0;
  assign out_data = mem[rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule

// --------------------------------------------------------------------
// port top
// --------------------------------------------------------------------
module sas_port
  import sas_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire sas_cfg_t CFG,
  input wire logic [15:0] BUF_WR_DATA,
  input wire logic BUF_WR_LOW,
  input wire logic BUF_WR_HIGH,
  output logic TX_READY,
  output logic [31:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  input wire logic OVERFLOW_CLEAR,
  output logic RECEIVE_OVERFLOW_FLAG,
  output logic ROUTE_DEDICATED,
  input wire logic SHIFT_CLOCK_IN,
  input wire logic SERIAL_DATA_IN,
  input wire logic SELECT_IN,
  output sas_link_t LINK_OUT
);
  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  logic srst;
  logic [4:0] wl_m1;
  logic [4:0] lim;
  logic spi_plain;
  logic uses_ss;
  logic sync_master;
  logic lag;
  logic pulse_sync;
  logic sync_act;

  assign srst = RST | ~CFG.port_enable;
  assign wl_m1 = (CFG.word_len_m1 < `SAS_LEN_MIN) ? `SAS_LEN_MIN : CFG.word_len_m1;
  assign spi_plain = !CFG.audio_enable && !CFG.framed;
  assign uses_ss = CFG.pins == SAS_PINS_4;
  assign sync_master = (!CFG.audio_enable && CFG.framed) ? CFG.frame_master : CFG.master;
  assign lag = CFG.audio_enable ? (CFG.audio_fmt == SAS_AUD_I2S ||
                                   CFG.audio_fmt == SAS_AUD_PCM) : 1'b1;
  assign pulse_sync = CFG.audio_enable ? (CFG.audio_fmt == SAS_AUD_PCM) : 1'b1;
  assign sync_act = CFG.audio_enable ? 1'b1 : CFG.frame_pol;

  always_comb begin
    if (!CFG.buffer_enhanced) begin
      lim = `SAS_LIM_STD;
    end else if (wl_m1 <= `SAS_LEN_8) begin
      lim = `SAS_LIM_8;
    end else if (wl_m1 <= `SAS_LEN_16) begin
      lim = `SAS_LIM_16;
    end else begin
      lim = `SAS_LIM_32;
    end
  end

  // ------------------------------------------------------------------
  // software buffer writes
  // ------------------------------------------------------------------
  logic [15:0] low_q;
  logic wr_push;
  logic [31:0] wr_word;
  logic tx_rdy;
  logic tx_ok;
  logic [4:0] tx_cnt;
  logic tx_valid;
  logic [31:0] tx_data;
  logic tx_pop;
  logic started;

  // each half is written whole, never merged bit by bit
  always_ff @(posedge SYS_CLK) begin
    if (srst) begin
      low_q <= 16'h0000;
    end else if (BUF_WR_LOW) begin
      low_q <= BUF_WR_DATA;
    end
  end

  assign wr_push = BUF_WR_HIGH | (BUF_WR_LOW & !CFG.audio_enable & (wl_m1 <= `SAS_LEN_16));
  assign wr_word = BUF_WR_HIGH ? {BUF_WR_DATA, low_q} : {16'h0000, BUF_WR_DATA};
  assign tx_ok = tx_rdy & (tx_cnt < lim);
  assign TX_READY = tx_ok;

  always_ff @(posedge SYS_CLK) begin
    if (srst) begin
      started <= 1'b0;
    end else if (CFG.audio_enable && BUF_WR_HIGH) begin
      started <= 1'b1;
    end
  end

  sas_fifo #(.W(`SAS_WORD_W), .D(`SAS_FIFO_DEPTH)) u_tx_fifo (
    .clk(SYS_CLK),
    .rst(srst),
    .in_valid(wr_push & tx_ok),
    .in_data(wr_word),
    .in_ready(tx_rdy),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_pop),
    .count(tx_cnt)
  );

  // ------------------------------------------------------------------
  // holding word handed to the link domain
  // ------------------------------------------------------------------
  logic [31:0] hold;
  logic hold_full;
  logic req_t;
  logic ack_seen;
  logic ak1;
  logic ak2;
  logic ack_t;

  always_ff @(posedge SYS_CLK) begin
    ak1 <= ack_t;
    ak2 <= ak1;
  end

  logic sl1;
  logic sl2;
  logic quasi;

  always_ff @(posedge SYS_CLK) begin
    sl1 <= SELECT_IN;
    sl2 <= sl1;
  end

  // a select-framed slave loads only while deselected, so the word settles before its first edge
  assign quasi = spi_plain && (CFG.master || uses_ss);
  assign tx_pop = !hold_full && tx_valid && (ak2 == ack_seen) && (CFG.master || !quasi || sl2);

  always_ff @(posedge SYS_CLK) begin
    if (srst) begin
      hold_full <= 1'b0;
      ack_seen <= ak2;
      hold <= `SAS_RST_WORD;
    end else if (ak2 != ack_seen) begin
      ack_seen <= ak2;
      hold_full <= 1'b0;
    end else if (tx_pop) begin
      hold <= tx_data;
      hold_full <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      req_t <= 1'b0;
    end else if (tx_pop && CFG.port_enable) begin
      req_t <= ~req_t;
    end
  end

  // ------------------------------------------------------------------
  // master shift clock generator
  // ------------------------------------------------------------------
  logic sck_q;
  logic busy;
  logic sent_t;
  logic [8:0] div_cnt;
  logic [8:0] half;
  logic [8:0] half_min;
  logic [5:0] edge_cnt;
  logic free_run;

  assign ROUTE_DEDICATED = ~CFG.dedicated_pin_select;
  assign half_min = CFG.dedicated_pin_select ? 9'(`SAS_REMAP_HALF) : 9'(`SAS_DED_HALF);
  assign half = ({1'b0, CFG.clk_div} + 9'h001 < half_min) ? half_min
              : {1'b0, CFG.clk_div} + 9'h001;
  assign free_run = CFG.master && (CFG.audio_enable ? started : CFG.framed);

  always_ff @(posedge SYS_CLK) begin
    if (srst) begin
      busy <= 1'b0;
      sent_t <= req_t;
    end else if (!busy && !free_run && CFG.master && spi_plain && hold_full &&
                 sent_t != req_t) begin
      busy <= 1'b1;
      sent_t <= req_t;
    end else if (busy && sck_q && div_cnt == half - 9'h001 && edge_cnt == {1'b0, wl_m1} + 6'h01) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (srst || !(free_run || busy)) begin
      sck_q <= 1'b0;
      div_cnt <= `SAS_RST_DIV;
      edge_cnt <= 6'h00;
    end else if (div_cnt == half - 9'h001) begin
      div_cnt <= `SAS_RST_DIV;
      sck_q <= ~sck_q;
      if (!sck_q && busy) begin
        edge_cnt <= edge_cnt + 6'h01;
      end
    end else begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  // ------------------------------------------------------------------
  // link domain: reset and request synchronisers
  // ------------------------------------------------------------------
  logic lr1;
  logic lr2;
  logic rq1;
  logic rq2;

  always_ff @(posedge SHIFT_CLOCK_IN) begin
    lr1 <= srst;
    lr2 <= lr1;
    rq1 <= req_t;
    rq2 <= rq1;
  end

  // ------------------------------------------------------------------
  // link domain: shifter and framing
  // ------------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [4:0] eff_cnt;
  logic ch;
  logic ss_prev;
  logic rx_t;
  logic [31:0] tx_sh;
  logic [31:0] rx_sh;
  logic [31:0] rx_word;
  logic evt;
  logic deselect;
  logic take;
  logic sdo_q;
  logic ss_q;
  logic [31:0] tx_aligned;
  logic link_rst;
  logic link_req;

  assign evt = uses_ss && !sync_master && !spi_plain &&
               (pulse_sync ? (SELECT_IN == sync_act && ss_prev != sync_act)
                           : (SELECT_IN != ss_prev));
  assign deselect = spi_plain && !CFG.master && uses_ss && SELECT_IN;
  assign eff_cnt = evt ? (lag ? wl_m1 : 5'h00) : bit_cnt;
  // own clock or select framing: request settles before the first edge, no edges to sync it
  assign link_rst = (CFG.master && spi_plain) ? srst : lr2;
  assign link_req = quasi ? req_t : rq2;
  assign take = link_req != ack_t;
  assign tx_aligned = hold << (5'h1F - wl_m1);

  always_ff @(posedge SHIFT_CLOCK_IN) begin
    if (link_rst) begin
      ss_prev <= 1'b1;
    end else begin
      ss_prev <= SELECT_IN;
    end
  end

  always_ff @(posedge SHIFT_CLOCK_IN) begin
    if (link_rst) begin
      bit_cnt <= `SAS_RST_CNT;
      ch <= 1'b0;
      ack_t <= link_req;
      tx_sh <= `SAS_RST_WORD;
    end else if (deselect) begin
      bit_cnt <= `SAS_RST_CNT;
    end else begin
      bit_cnt <= (eff_cnt == wl_m1) ? `SAS_RST_CNT : eff_cnt + 5'h01;
      if (eff_cnt == wl_m1) begin
        ch <= ~ch;
      end
      if (eff_cnt == 5'h00) begin
        tx_sh <= take ? (tx_aligned << 1) : `SAS_RST_WORD;
        if (take) begin
          ack_t <= ~ack_t;
        end
      end else begin
        tx_sh <= tx_sh << 1;
      end
    end
  end

  always_ff @(posedge SHIFT_CLOCK_IN) begin
    if (link_rst) begin
      rx_sh <= `SAS_RST_WORD;
      rx_word <= `SAS_RST_WORD;
      rx_t <= 1'b0;
    end else if (!deselect) begin
      rx_sh <= {rx_sh[30:0], SERIAL_DATA_IN};
      if (eff_cnt == wl_m1) begin
        rx_word <= {rx_sh[30:0], SERIAL_DATA_IN} & (32'hFFFFFFFF >> (5'h1F - wl_m1));
        rx_t <= ~rx_t;
      end
    end
  end

  // outputs change on the falling edge, sampled by the far side on the rising one
  always_ff @(negedge SHIFT_CLOCK_IN) begin
    if (link_rst) begin
      sdo_q <= 1'b0;
      ss_q <= 1'b1;
    end else begin
      sdo_q <= tx_sh[31];
      if (CFG.audio_enable) begin
        case (CFG.audio_fmt)
          SAS_AUD_I2S: ss_q <= (bit_cnt == wl_m1) ? ~ch : ch;
          SAS_AUD_PCM: ss_q <= (bit_cnt == wl_m1) && ch;
          default: ss_q <= ~ch;
        endcase
      end else begin
        ss_q <= (bit_cnt == wl_m1) ? CFG.frame_pol : ~CFG.frame_pol;
      end
    end
  end

  // ------------------------------------------------------------------
  // pins
  // ------------------------------------------------------------------
  always_comb begin
    LINK_OUT.serial_data_out = (bit_cnt == 5'h00) ? (take & hold[wl_m1]) : sdo_q;
    LINK_OUT.serial_data_oe = CFG.port_enable && CFG.pins != SAS_PINS_2 && !deselect;
    LINK_OUT.shift_clock_out = sck_q;
    LINK_OUT.shift_clock_oe = CFG.port_enable && CFG.master;
    LINK_OUT.select_out = spi_plain ? ~busy : ss_q;
    LINK_OUT.select_oe = CFG.port_enable && uses_ss && sync_master;
  end

  // ------------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------------
  logic rt1;
  logic rt2;
  logic rt_seen;
  logic rx_evt;
  logic rx_rdy;
  logic rx_ok;
  logic [4:0] rx_cnt;

  always_ff @(posedge SYS_CLK) begin
    rt1 <= rx_t;
    rt2 <= rt1;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rt_seen <= 1'b0;
    end else begin
      rt_seen <= rt2;
    end
  end

  assign rx_evt = (rt2 != rt_seen) && CFG.port_enable;
  assign rx_ok = rx_rdy && (rx_cnt < lim);

  sas_fifo #(.W(`SAS_WORD_W), .D(`SAS_FIFO_DEPTH)) u_rx_fifo (
    .clk(SYS_CLK),
    .rst(srst),
    .in_valid(rx_evt & rx_ok),
    .in_data(rx_word),
    .in_ready(rx_rdy),
    .out_valid(RX_VALID),
    .out_data(RX_DATA),
    .out_ready(RX_READY),
    .count(rx_cnt)
  );

  // flag is cleared by software before enabling audio
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RECEIVE_OVERFLOW_FLAG <= 1'b0;
    end else begin
      RECEIVE_OVERFLOW_FLAG <= (RECEIVE_OVERFLOW_FLAG & ~OVERFLOW_CLEAR) |
                               (rx_evt & ~rx_ok);
    end
  end
endmodule

/* File: sim/sas_port_chk.sv */
// concurrent checks on the ports of the serial audio port
// assumes sas_pkg compiled first; bound to every sas_port
`timescale 1ns/1ps
module sas_port_chk
  import sas_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire sas_cfg_t CFG,
  input wire logic BUF_WR_LOW,
  input wire logic TX_READY,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic OVERFLOW_CLEAR,
  input wire logic RECEIVE_OVERFLOW_FLAG,
  input wire logic ROUTE_DEDICATED,
  input wire logic SELECT_IN,
  input wire sas_link_t LINK_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_route;
    ROUTE_DEDICATED == !CFG.dedicated_pin_select;
  endproperty
  a_route: assert property (p_route) else $error("routing select wrong");
  property p_rst;
    disable iff (1'h0) RST ##1 RST |-> TX_READY && !RX_VALID && !RECEIVE_OVERFLOW_FLAG;
  endproperty
  a_rst: assert property (p_rst) else $error("buffer state in reset wrong");
  property p_std;
    CFG.port_enable && !CFG.master && !CFG.buffer_enhanced && !CFG.audio_enable && !CFG.framed
      && SELECT_IN && CFG.word_len_m1 <= 5'h0F && BUF_WR_LOW && TX_READY |=> !TX_READY;
  endproperty
  a_std: assert property (p_std) else $error("single buffer took two words");
  property p_sticky;
    RECEIVE_OVERFLOW_FLAG && !OVERFLOW_CLEAR |=> RECEIVE_OVERFLOW_FLAG;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
  property p_rise;
    $rose(RECEIVE_OVERFLOW_FLAG) |-> $past(RX_VALID);
  endproperty
  a_rise: assert property (p_rise) else $error("overflow flag with empty buffer");
  property p_pins;
    CFG.port_enable && CFG.pins != SAS_PINS_4 |-> !LINK_OUT.select_oe
      && (CFG.pins != SAS_PINS_2 || !LINK_OUT.serial_data_oe);
  endproperty
  a_pins: assert property (p_pins) else $error("unused pin driven");
  property p_idle;
    CFG.port_enable && CFG.master && !CFG.audio_enable && !CFG.framed
      && CFG.pins == SAS_PINS_4 && LINK_OUT.select_out |-> !LINK_OUT.shift_clock_out;
  endproperty
  a_idle: assert property (p_idle) else $error("clock not idle low");
  property p_aud;
    CFG.port_enable && CFG.audio_enable && CFG.master && $rose(LINK_OUT.shift_clock_out)
      |-> ##[1:600] ($fell(LINK_OUT.shift_clock_out) || !CFG.port_enable);
  endproperty
  a_aud: assert property (p_aud) else $error("audio clock stalled");
  property p_release;
    (CFG.port_enable && !CFG.master && !CFG.framed && !CFG.audio_enable
      && CFG.pins == SAS_PINS_4 && SELECT_IN) [*4] |-> !LINK_OUT.serial_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("data driven while deselected");
  property p_drive;
    $stable(CFG) ##1 ($stable(CFG) && CFG.port_enable && CFG.pins == SAS_PINS_4 && CFG.master
      && (CFG.audio_enable || CFG.framed && CFG.frame_master))
      |-> LINK_OUT.shift_clock_oe && LINK_OUT.select_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("master clocks not driven");
  c_ovf: cover property ($rose(RECEIVE_OVERFLOW_FLAG));
  c_pop: cover property (RX_VALID && RX_READY);
  c_aud: cover property (CFG.audio_enable && $rose(LINK_OUT.shift_clock_out));
endmodule

bind sas_port sas_port_chk i_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .CFG(CFG), .BUF_WR_LOW(BUF_WR_LOW), .TX_READY(TX_READY),
  .RX_VALID(RX_VALID), .RX_READY(RX_READY), .OVERFLOW_CLEAR(OVERFLOW_CLEAR),
  .RECEIVE_OVERFLOW_FLAG(RECEIVE_OVERFLOW_FLAG), .ROUTE_DEDICATED(ROUTE_DEDICATED),
  .SELECT_IN(SELECT_IN), .LINK_OUT(LINK_OUT)
);

/* File: sim/sas_peer.sv */
// serial peer on the far side of the link: master or slave
// assumes the bench calls xfer and tick and sets reply
`timescale 1ns/1ps
module sas_peer (
  input wire logic sck_in,
  input wire logic sel_in,
  input wire logic din,
  output logic sck_o,
  output logic sel_o,
  output logic sdo
);
  logic [31:0] reply;
  logic [31:0] cap;
  initial begin
    sck_o = 1'h0;
    sel_o = 1'h1;
    sdo = 1'h0;
    reply = 32'h00000000;
    cap = 32'h00000000;
  end
  // ------------------------------------------------------------------
  // master role: select low over the frame, msb first
  // ------------------------------------------------------------------
  task automatic xfer(input logic [31:0] w, input int n);
    #7 sel_o = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sdo = w[i];
      #32 sck_o = 1'h1;
      cap = {cap[30:0], din};
      #32 sck_o = 1'h0;
    end
    #32 sel_o = 1'h1;
    sdo = ~sdo;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      #7 sck_o = 1'h1;
      #32 sck_o = 1'h0;
      #25;
    end
  endtask
  // ------------------------------------------------------------------
  // slave role behind a master port
  // ------------------------------------------------------------------
  always @(negedge sel_in) if (sel_o) begin
    sdo = reply[31];
    reply = reply << 1;
  end
  always @(negedge sck_in) if (sel_o && !sel_in) begin
    sdo = reply[31];
    reply = reply << 1;
  end
  always @(posedge sck_in) if (sel_o && !sel_in) cap = {cap[30:0], din};
  always @(posedge sel_in) if (sel_o) sdo = ~sdo;
endmodule

/* File: sim/test_spi_audio_serial_port.sv */
// self-checking bench of the serial audio port
// assumes sas_pkg, sas_port, sas_peer and the checker compiled first
`timescale 1ns/1ps
`include "sas_params.svh"
module test_spi_audio_serial_port
  import sas_pkg::*;
;
  logic clk, rst, wr_low, wr_high, rx_ready, ovf_clr, tx_ready, rx_valid, ovf, route;
  logic [15:0] wdata;
  logic [31:0] rx_data;
  sas_cfg_t cfg;
  sas_link_t link;
  logic p_sck, p_sel, p_sdo, sck, ssel;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  assign sck = link.shift_clock_oe ? link.shift_clock_out : p_sck;
  assign ssel = link.select_oe ? link.select_out : p_sel;
  sas_port i_dut (
    .SYS_CLK(clk), .RST(rst), .CFG(cfg), .BUF_WR_DATA(wdata), .BUF_WR_LOW(wr_low),
    .BUF_WR_HIGH(wr_high), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .OVERFLOW_CLEAR(ovf_clr), .RECEIVE_OVERFLOW_FLAG(ovf),
    .ROUTE_DEDICATED(route), .SHIFT_CLOCK_IN(sck), .SERIAL_DATA_IN(p_sdo),
    .SELECT_IN(ssel), .LINK_OUT(link)
  );
  sas_peer i_peer (.sck_in(sck), .sel_in(ssel), .din(link.serial_data_out), .sck_o(p_sck),
    .sel_o(p_sel), .sdo(p_sdo));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    checks++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask
  function automatic sas_cfg_t base(input logic m, input logic [4:0] wl);
    sas_cfg_t c;
    c = '0;
    c.port_enable = 1'h1;
    c.master = m;
    c.word_len_m1 = wl;
    return c;
  endfunction
  task automatic setup(input sas_cfg_t c);
    @(negedge clk);
    cfg.port_enable = 1'h0;
    @(negedge clk);
    c.port_enable = 1'h0;
    cfg = c;
    ovf_clr = 1'h1;
    i_peer.tick(3);
    @(negedge clk);
    ovf_clr = 1'h0;
    cfg.port_enable = 1'h1;
    i_peer.tick(3);
    repeat (4) @(negedge clk);
  endtask
  task automatic push(input logic [31:0] w, input logic hi);
    @(negedge clk);
    wdata = w[15:0];
    wr_low = 1'h1;
    @(negedge clk);
    wr_low = 1'h0;
    if (hi) begin
      wdata = w[31:16];
      wr_high = 1'h1;
      @(negedge clk);
      wr_high = 1'h0;
    end
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 200 && rx_valid !== 1'h1; i++) @(negedge clk);
    chk(rx_valid === 1'h1, "no received word");
  endtask
  task automatic pop();
    @(negedge clk);
    rx_ready = 1'h1;
    @(negedge clk);
    rx_ready = 1'h0;
  endtask
  task automatic watch(input int cyc, output int r, output int t, output int h);
    logic s, l;
    r = 0;
    t = 0;
    h = 0;
    s = link.shift_clock_out;
    l = link.select_out;
    repeat (cyc) begin
      @(negedge clk);
      if (link.shift_clock_out === 1'h1 && s === 1'h0) r++;
      if (link.select_out !== l) t++;
      if (link.select_out === 1'h1) h++;
      s = link.shift_clock_out;
      l = link.select_out;
    end
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk(tx_ready === 1'h1 && rx_valid === 1'h0 && ovf === 1'h0, "reset state");
    for (int d = 0; d < 2; d++) begin
      @(negedge clk);
      cfg.dedicated_pin_select = d[0];
      @(negedge clk);
      chk(route === ~d[0], "route select");
    end
    $display("reset test done");
  endtask
  task automatic t_depth(input logic enh, input logic [4:0] wl, input int exp);
    sas_cfg_t c;
    int n;
    c = base(1'h0, wl);
    c.buffer_enhanced = enh;
    setup(c);
    n = 0;
    while (tx_ready === 1'h1 && n < 8) begin
      push(32'h000000A5 + n, wl > 5'h0F);
      repeat (3) @(negedge clk);
      n++;
    end
    // one word moves on into the holding stage
    chk(n == exp + 1 && tx_ready === 1'h0, "buffer depth");
    $display("depth test done");
  endtask
  task automatic t_slave(input logic [4:0] wl, input logic [31:0] tw, input logic [31:0] rw);
    logic [31:0] m;
    m = 32'hFFFFFFFF >> (5'h1F - wl);
    setup(base(1'h0, wl));
    push(tw, wl > 5'h0F);
    i_peer.xfer(rw, wl + 1);
    wait_rx();
    chk(rx_data === (rw & m), "slave received word");
    chk((i_peer.cap & m) === (tw & m), "slave sent word");
    pop();
    $display("slave test done");
  endtask
  task automatic t_ovf();
    setup(base(1'h0, 5'h07));
    i_peer.xfer(32'h00000011, 8);
    wait_rx();
    i_peer.xfer(32'h00000022, 8);
    repeat (10) @(negedge clk);
    chk(ovf === 1'h1 && rx_data === 32'h00000011, "overflow");
    ovf_clr = 1'h1;
    @(negedge clk);
    ovf_clr = 1'h0;
    @(negedge clk);
    chk(ovf === 1'h0, "overflow clear");
    pop();
    $display("overflow test done");
  endtask
  task automatic t_master();
    setup(base(1'h1, 5'h07));
    i_peer.reply = 32'hC3000000;
    push(32'h0000005A, 1'h0);
    wait_rx();
    repeat (20) @(negedge clk);
    chk(rx_data === 32'h000000C3 && i_peer.cap[7:0] === 8'h5A, "master word");
    chk(link.select_out === 1'h1 && link.shift_clock_out === 1'h0, "master idle");
    pop();
    $display("master test done");
  endtask
  task automatic t_pins(input sas_pins_t p);
    sas_cfg_t c;
    c = base(1'h1, 5'h07);
    c.pins = p;
    setup(c);
    chk(link.select_oe === (p == SAS_PINS_4), "select drive");
    if (p == SAS_PINS_2) chk(link.serial_data_oe === 1'h0, "data out drive");
    $display("pins test done");
  endtask
  task automatic t_frame(input logic fm, input logic fp);
    sas_cfg_t c;
    int r, t, h;
    c = base(1'h1, 5'h07);
    c.framed = 1'h1;
    c.frame_master = fm;
    c.frame_pol = fp;
    setup(c);
    push(32'h00000096, 1'h0);
    watch(400, r, t, h);
    chk(link.select_oe === fm, "frame sync drive");
    if (fm) chk(t >= 2 && (fp ? h < 200 : h > 200), "frame pulse");
    $display("frame test done");
  endtask
  task automatic t_audio(input sas_audio_t f, input logic ded);
    sas_cfg_t c;
    int r, t, h, per;
    per = ded ? 2 * `SAS_REMAP_HALF : 2 * `SAS_DED_HALF;
    c = base(1'h1, 5'h0F);
    c.audio_enable = 1'h1;
    c.audio_fmt = f;
    c.dedicated_pin_select = ded;
    setup(c);
    watch(120, r, t, h);
    chk(r == 0, "clock before load");
    push(32'h1234ABCD, 1'h1);
    repeat (20) @(negedge clk);
    watch(800, r, t, h);
    chk(r >= 800 / per - 1 && r <= 800 / per + 1, "audio clock rate");
    chk(t >= 2, "channel clock");
    $display("audio test done");
  endtask
  initial begin
    rst = 1'h1;
    cfg = '0;
    wdata = 16'h0000;
    wr_low = 1'h0;
    wr_high = 1'h0;
    rx_ready = 1'h0;
    ovf_clr = 1'h0;
    repeat (10) @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_depth(1'h0, 5'h07, 1);
    t_depth(1'h1, 5'h07, 4);
    t_depth(1'h1, 5'h0F, 2);
    t_depth(1'h1, 5'h1F, 1);
    t_slave(5'h01, 32'h00000002, 32'h00000001);
    t_slave(5'h07, 32'h000000A5, 32'h0000003C);
    t_slave(5'h1F, 32'h89ABCDEF, 32'h12345678);
    t_ovf();
    t_master();
    for (int p = 0; p < 3; p++) t_pins(sas_pins_t'(p));
    for (int f = 0; f < 4; f++) t_frame(f[1], f[0]);
    for (int f = 0; f < 4; f++) t_audio(sas_audio_t'(f), f[0]);
    give_verdict();
  end
endmodule
